// [core/timer_control_register.sv]
// Timer control register, APB slave and 16-bit counting core
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module timer_control_register (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idle_mode,
  input wire logic external_count_input,
  input wire logic gate_input,
  output logic [15:0] timer_count,
  output logic timer_active
);
  timer_pkg::main_state_s st_reg;
  timer_pkg::main_state_s st_next;
  logic setup;
  logic access;
  logic wr_ctrl;
  logic wr_count;
  logic ext_rise;
  logic src_tick;
  logic run_tick;
  logic running;
  logic prescale_clear;

  // ========================================================================
  // APB decode
  assign setup = psel & ~penable;
  assign access = psel & penable;
  // Zero wait states in access; read data is prepared in setup
  assign pready = access;
  assign wr_ctrl = access & pwrite & (paddr == timer_pkg::CTRL_OFFSET);
  assign wr_count = access & pwrite & (paddr == timer_pkg::COUNT_OFFSET);
  assign prdata = st_reg.prdata;
  assign pslverr = st_reg.pslverr & access;
  assign timer_count = st_reg.count;
  assign timer_active = running;

  // ========================================================================
  // Clock source selection
  count_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin_level(external_count_input),
    .rise(ext_rise)
  );

  always_comb begin
    if (st_reg.ctrl.src) begin
      src_tick = ext_rise;
    end else if (st_reg.ctrl.gate) begin
      src_tick = st_reg.int_phase & gate_input;
    end else begin
      src_tick = st_reg.int_phase;
    end
  end

  assign running = st_reg.state == timer_pkg::ST_RUNNING;
  // Control writes restart the division so a new ratio starts clean
  assign prescale_clear = ~st_reg.ctrl.run | wr_ctrl | wr_count;

  input_prescaler u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .clear(prescale_clear),
    .enable(running),
    .tick_in(src_tick),
    .div_sel(st_reg.ctrl.div),
    .tick_out(run_tick)
  );

  // ========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    // Internal clock is oscillator over OSC_PER_INT_TICK, a free toggle
    st_next.int_phase = ~st_reg.int_phase;
    unique case (st_reg.state)
      timer_pkg::ST_STOPPED: begin
        if (st_reg.ctrl.run) begin
          st_next.state = timer_pkg::ST_RUNNING;
        end
      end
      timer_pkg::ST_RUNNING: begin
        if (!st_reg.ctrl.run) begin
          st_next.state = timer_pkg::ST_STOPPED;
        end else if (st_reg.ctrl.idle_halt && idle_mode) begin
          st_next.state = timer_pkg::ST_IDLE_HALT;
        end
      end
      timer_pkg::ST_IDLE_HALT: begin
        if (!st_reg.ctrl.run) begin
          st_next.state = timer_pkg::ST_STOPPED;
        end else if (!(st_reg.ctrl.idle_halt && idle_mode)) begin
          st_next.state = timer_pkg::ST_RUNNING;
        end
      end
      default: begin
        st_next.state = timer_pkg::ST_STOPPED;
      end
    endcase
    // Software write to the count wins over a tick in the same cycle
    if (wr_count) begin
      st_next.count = pwdata[15:0];
    end else if (run_tick) begin
      st_next.count = st_reg.count + 16'h0001;
    end
    if (wr_ctrl) begin
      st_next.ctrl = timer_pkg::word_to_ctrl(pwdata[15:0]);
    end
    if (setup) begin
      st_next.pslverr = 1'b0;
      unique case (paddr)
        timer_pkg::CTRL_OFFSET: begin
          st_next.prdata = {16'h0000, timer_pkg::ctrl_to_word(st_reg.ctrl)};
        end
        timer_pkg::COUNT_OFFSET: begin
          st_next.prdata = {16'h0000, st_reg.count};
        end
        default: begin
          st_next.prdata = timer_pkg::RDATA_RESET;
          st_next.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{ctrl: timer_pkg::word_to_ctrl(timer_pkg::CTRL_RESET),
                  count: timer_pkg::COUNT_RESET,
                  int_phase: 1'b0,
                  state: timer_pkg::ST_STOPPED,
                  prdata: timer_pkg::RDATA_RESET,
                  pslverr: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_run_starts_timer: assert property (
    wr_ctrl && pwdata[timer_pkg::RUN_BIT] && !idle_mode |=> ##1 running)
    else $error("timer did not start after run was set");

  a_stop_holds_count: assert property (
    !running && !wr_count |=> timer_count == $past(timer_count))
    else $error("count moved while timer was stopped");

  a_idle_halt_enter: assert property (
    running && st_reg.ctrl.run && st_reg.ctrl.idle_halt && idle_mode
      |=> st_reg.state == timer_pkg::ST_IDLE_HALT)
    else $error("timer did not halt in idle mode");

  a_idle_keep_running: assert property (
    running && st_reg.ctrl.run && !st_reg.ctrl.idle_halt && idle_mode |=> running)
    else $error("timer halted in idle without idle halt");

  a_gate_low_blocks: assert property (
    running && !st_reg.ctrl.src && st_reg.ctrl.gate && !gate_input && !wr_count
      |=> timer_count == $past(timer_count))
    else $error("gated count advanced with gate low");

  a_ext_gate_ignored: assert property (
    running && st_reg.ctrl.src && st_reg.ctrl.gate && !gate_input && ext_rise
      && st_reg.ctrl.div == timer_pkg::DIV_1 && !wr_count && !wr_ctrl
      |=> timer_count == $past(timer_count) + 16'h0001)
    else $error("external edge lost with gate enabled");

  a_ext_edge_counts: assert property (
    running && st_reg.ctrl.src && !ext_rise && !wr_count |=> timer_count == $past(timer_count))
    else $error("external source counted without a rising edge");

  a_internal_half_rate: assert property (
    running && !st_reg.ctrl.src && !st_reg.ctrl.gate && st_reg.ctrl.div == timer_pkg::DIV_1
      && !wr_count && !wr_ctrl
      |=> timer_count == $past(timer_count) + {15'h0000, $past(st_reg.int_phase)})
    else $error("internal source not at half clock rate");

  a_reserved_read_zero: assert property (
    access && !pwrite && paddr == timer_pkg::CTRL_OFFSET
      |-> (prdata & ~{16'h0000, timer_pkg::CTRL_IMPL_MASK}) == 32'h0000_0000)
    else $error("reserved control bits read nonzero");

  a_div_by8_stride: assert property (
    running && run_tick && st_reg.ctrl.div == timer_pkg::DIV_8 && st_reg.ctrl.src
      |=> (!run_tick || st_reg.ctrl.div != timer_pkg::DIV_8 || !st_reg.ctrl.src) [*7])
    else $error("divide by eight ticked too soon");

  c_ext_count: cover property (running && st_reg.ctrl.src && run_tick);
  c_gated_count: cover property (running && st_reg.ctrl.gate && !st_reg.ctrl.src && run_tick);
  c_idle_halt: cover property (st_reg.state == timer_pkg::ST_IDLE_HALT);
  c_slverr: cover property (pslverr);
endmodule // timer_control_register
`default_nettype wire

// [inc/timer_pkg.sv]
// Package: offsets, fields, reset values and types of the timer control block
// ==========================================================================
// How it works
// - Writing the run bit to one starts the 16-bit counter counting.
// - Clearing the run bit to zero stops the counter so it no longer advances.
// - With idle halt set, counting is suspended while the chip is in Idle mode.
// - With idle halt clear, counting goes on normally in Idle mode.
// - On the internal source the gate bit selects gated accumulation or plain counting.
// - On the external source the gate bit is ignored whatever its value.
// - The two-bit field at bits 5-4 divides the input by 256, 64, 8 or 1 for 11, 10, 01, 00.
// - Source bit one clocks the counter from rising edges of the external count pin.
// - Source bit zero clocks the counter from the internal clock at half the oscillator rate.
// - Control bits 14, 12-7, 3-2 and 0 read as zero and ignore writes.
package timer_pkg;

  // ========================================================================
  // Register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] COUNT_OFFSET = 8'h04;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // ========================================================================
  // Control field positions
  localparam int unsigned RUN_BIT = 15;
  localparam int unsigned IDLE_HALT_BIT = 13;
  localparam int unsigned GATE_BIT = 6;
  localparam int unsigned DIV_LSB = 4;
  localparam int unsigned SRC_BIT = 1;
  localparam logic [15:0] CTRL_IMPL_MASK = 16'hA072;

  // ========================================================================
  // Timing and divider codes
  localparam int unsigned OSC_PER_INT_TICK = 2;
  localparam logic [1:0] DIV_1 = 2'b00;
  localparam logic [1:0] DIV_8 = 2'b01;
  localparam logic [1:0] DIV_64 = 2'b10;
  localparam logic [1:0] DIV_256 = 2'b11;
  localparam logic [7:0] LIMIT_1 = 8'h00;
  localparam logic [7:0] LIMIT_8 = 8'h07;
  localparam logic [7:0] LIMIT_64 = 8'h3F;
  localparam logic [7:0] LIMIT_256 = 8'hFF;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;

  // ========================================================================
  // Types
  typedef struct packed {
    logic run;
    logic idle_halt;
    logic gate;
    logic [1:0] div;
    logic src;
  } ctrl_s;

  typedef enum logic [1:0] {
    ST_STOPPED = 2'b00,
    ST_RUNNING = 2'b01,
    ST_IDLE_HALT = 2'b11
  } run_state_e;

  typedef struct packed {
    ctrl_s ctrl;
    logic [15:0] count;
    logic int_phase;
    run_state_e state;
    logic [31:0] prdata;
    logic pslverr;
  } main_state_s;

  typedef struct packed {
    logic [7:0] cnt;
  } prescale_state_s;

  // ========================================================================
  // Helpers
  function automatic logic [7:0] divider_limit(input logic [1:0] div);
    unique case (div)
      DIV_1: divider_limit = LIMIT_1;
      DIV_8: divider_limit = LIMIT_8;
      DIV_64: divider_limit = LIMIT_64;
      DIV_256: divider_limit = LIMIT_256;
    endcase
  endfunction

  function automatic logic [15:0] ctrl_to_word(input ctrl_s c);
    logic [15:0] w;
    w = 16'h0000;
    w[RUN_BIT] = c.run;
    w[IDLE_HALT_BIT] = c.idle_halt;
    w[GATE_BIT] = c.gate;
    w[DIV_LSB +: 2] = c.div;
    w[SRC_BIT] = c.src;
    return w;
  endfunction

  function automatic ctrl_s word_to_ctrl(input logic [15:0] w);
    ctrl_s c;
    c.run = w[RUN_BIT];
    c.idle_halt = w[IDLE_HALT_BIT];
    c.gate = w[GATE_BIT];
    c.div = w[DIV_LSB +: 2];
    c.src = w[SRC_BIT];
    return c;
  endfunction

endpackage

// [core/count_edge_detect.sv]
// Rising edge detector for the external count pin
`timescale 1ns/1ps
`default_nettype none
module count_edge_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_level,
  output logic rise
);
  logic prev_reg;
  logic prev_next;

  // ========================================================================
  // Edge logic
  always_comb begin
    prev_next = pin_level;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Reset high: a pin already high at release must not look like an edge
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= prev_next;
    end
  end

  // Pin is taken as synchronous, so one flop suffices
  assign rise = pin_level & ~prev_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rise_single_pulse: assert property (rise |=> !rise)
    else $error("edge pulse lasted more than one cycle");
endmodule // count_edge_detect
`default_nettype wire

// [core/input_prescaler.sv]
// Input clock prescaler: passes one tick in 1, 8, 64 or 256
`timescale 1ns/1ps
`default_nettype none
module input_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic enable,
  input wire logic tick_in,
  input wire logic [1:0] div_sel,
  output logic tick_out
);
  timer_pkg::prescale_state_s st_reg;
  timer_pkg::prescale_state_s st_next;
  logic at_limit;

  // ========================================================================
  // Divider
  assign at_limit = st_reg.cnt >= timer_pkg::divider_limit(div_sel);
  assign tick_out = enable & tick_in & at_limit;

  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next.cnt = timer_pkg::PRESCALE_RESET;
    end else if (enable && tick_in) begin
      // Compare with >= so a smaller ratio chosen mid-count cannot stall
      st_next.cnt = at_limit ? timer_pkg::PRESCALE_RESET : st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{cnt: timer_pkg::PRESCALE_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_prescale_wrap: assert property (tick_out && !clear |=> st_reg.cnt == 8'h00)
    else $error("prescaler did not restart after a tick");
  a_div8_spacing: assert property (
    tick_out && div_sel == timer_pkg::DIV_8 && !clear
      ##1 (div_sel == timer_pkg::DIV_8 && !clear)[*7] |-> st_reg.cnt <= 8'h07)
    else $error("divide by eight count out of range");
  c_div256_tick: cover property (tick_out && div_sel == timer_pkg::DIV_256);
endmodule // input_prescaler
`default_nettype wire

// [tb/timer_control_register_bench.sv]
// Self-checking bench for the timer control register block
`timescale 1ns/1ps
`default_nettype none
module timer_control_register_bench;
  // ==========================================================
  // Clock, reset and pins
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic idle_mode = 1'b0;
  logic gate_input = 1'b0;
  logic [1:0] ph = 2'h0;
  logic [15:0] timer_count;
  logic timer_active;
  int errors = 0;
  int checked = 0;

  always #2.5 pclk = ~pclk;
  // Pin rises once in four clocks, half the internal rate, so the sources differ
  always @(posedge pclk) ph <= ph + 2'h1;

  timer_control_register i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .idle_mode(idle_mode),
    .external_count_input(ph[1]),
    .gate_input(gate_input),
    .timer_count(timer_count),
    .timer_active(timer_active)
  );

  // ==========================================================
  // Compare, bus and closing tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One idle edge first, so psel is never driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 20) chk(32'h0, 32'h1, "pready timeout");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {16'h0000, d}, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eexp,
                        input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp, what);
    chk({31'h0, e}, {31'h0, eexp}, "slave error");
  endtask

  task automatic reset_chk();
    chk({16'h0, timer_count}, 32'h0, "count at reset");
    chk({31'h0, timer_active}, 32'h0, "active at reset");
    rd_chk(8'h00, 32'h0, 1'b0, "ctrl at reset");
  endtask

  // ==========================================================
  // Counting cases: windows are whole tick periods, so deltas are exact
  typedef struct {
    logic [15:0] ctrl;
    logic gate;
    logic idle;
    int cyc;
    logic [15:0] delta;
    logic act;
  } row_s;
  row_s rows[13] = '{
    '{16'h8000, 1'b0, 1'b0, 64, 16'h0020, 1'b1},
    '{16'h8010, 1'b0, 1'b0, 256, 16'h0010, 1'b1},
    '{16'h8020, 1'b0, 1'b0, 1024, 16'h0008, 1'b1},
    '{16'h8030, 1'b0, 1'b0, 2048, 16'h0004, 1'b1},
    '{16'h8002, 1'b0, 1'b0, 64, 16'h0010, 1'b1},
    '{16'h8012, 1'b0, 1'b0, 256, 16'h0008, 1'b1},
    '{16'h8040, 1'b0, 1'b0, 64, 16'h0000, 1'b1},
    '{16'h8040, 1'b1, 1'b0, 64, 16'h0020, 1'b1},
    '{16'h8042, 1'b0, 1'b0, 64, 16'h0010, 1'b1},
    '{16'hA000, 1'b0, 1'b1, 64, 16'h0000, 1'b0},
    '{16'hA000, 1'b0, 1'b0, 64, 16'h0020, 1'b1},
    '{16'h8000, 1'b0, 1'b1, 64, 16'h0020, 1'b1},
    '{16'h0032, 1'b0, 1'b0, 64, 16'h0000, 1'b0}
  };

  // ==========================================================
  // Main sequence
  initial begin
    logic [15:0] c0;
    logic [31:0] r;
    logic e;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reset_chk();
    foreach (rows[i]) begin
      @(posedge pclk);
      gate_input <= rows[i].gate;
      idle_mode <= rows[i].idle;
      wr(8'h00, rows[i].ctrl);
      rd_chk(8'h00, {16'h0000, rows[i].ctrl & 16'hA072}, 1'b0, "ctrl readback");
      repeat (4) @(negedge pclk);
      c0 = timer_count;
      repeat (rows[i].cyc) @(negedge pclk);
      chk({16'h0, timer_count - c0}, {16'h0, rows[i].delta}, "count delta");
      chk({31'h0, timer_active}, {31'h0, rows[i].act}, "active flag");
    end
    idle_mode <= 1'b0;
    wr(8'h00, 16'hFFFF);
    rd_chk(8'h00, 32'h0000_A072, 1'b0, "all ones");
    wr(8'h00, 16'h5F8D);
    rd_chk(8'h00, 32'h0000_0000, 1'b0, "unused bits");
    wr(8'h04, 16'hBEEF);
    rd_chk(8'h04, 32'h0000_BEEF, 1'b0, "count held");
    apb(1'b1, 8'h08, 32'h0000_FFFF, r, e);
    chk({31'h0, e}, 32'h1, "unmapped write");
    rd_chk(8'h08, 32'h0, 1'b1, "unmapped read");
    rd_chk(8'h00, 32'h0, 1'b0, "ctrl kept");
    // Start and stop back to back, then the count must stay frozen
    wr(8'h00, 16'h8000);
    wr(8'h00, 16'h0000);
    @(negedge pclk);
    c0 = timer_count;
    repeat (32) @(negedge pclk);
    chk({16'h0, timer_count}, {16'h0, c0}, "frozen after stop");
    // Reset in mid-run
    wr(8'h00, 16'h8000);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reset_chk();
    tally_and_finish();
  end

  // Run needs about 4400 clocks; a hang is cut off well beyond that
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    tally_and_finish();
  end
endmodule // timer_control_register_bench
`default_nettype wire
